// File: dpc_sync.sv
// ----------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------
package dpc_pkg;
  localparam int DPC_SYNC_STAGES = 2;
  localparam int DPC_NUM_INPUTS = 3;
  localparam int DPC_IDX_REF = 0;
  localparam int DPC_IDX_FB = 1;
  localparam int DPC_IDX_DIS = 2;
  localparam logic DPC_RST_LEVEL = 1'b0;
  localparam logic DPC_RST_LOCK = 1'b1;
  localparam logic DPC_RST_OSC_DIS = 1'b1;

  // drive mode of the edge comparator
  typedef enum logic [1:0]
  {
    DPC_MODE_OFF = 2'b00,
    DPC_MODE_UP = 2'b01,
    DPC_MODE_DN = 2'b11
  } dpc_mode_t;

  // twelve states, named by number; codes are mode,ref,fb
  typedef enum logic [3:0]
  {
    DPC_ST1 = 4'h0,
    DPC_ST6 = 4'h1,
    DPC_ST8 = 4'h3,
    DPC_ST7 = 4'h2,
    DPC_ST3 = 4'h6,
    DPC_ST5 = 4'h7,
    DPC_ST11 = 4'h5,
    DPC_ST9 = 4'h4,
    DPC_ST2 = 4'hc,
    DPC_ST4 = 4'hd,
    DPC_ST12 = 4'hf,
    DPC_ST10 = 4'he
  } dpc_state_t;
  localparam dpc_state_t DPC_RST_STATE = DPC_ST1;
endpackage : dpc_pkg

// ----------------------------------------------------------------------
// two-flop synchroniser for the pin inputs
// ----------------------------------------------------------------------
module dpc_sync
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [DPC_NUM_INPUTS-1:0] pin_in,
  input wire logic [DPC_NUM_INPUTS-1:0] rst_val,
  output logic [DPC_NUM_INPUTS-1:0] sync_out
);
  logic [DPC_NUM_INPUTS-1:0] meta_q;
  logic [DPC_NUM_INPUTS-1:0] meta_d;
  logic [DPC_NUM_INPUTS-1:0] sync_q;
  logic [DPC_NUM_INPUTS-1:0] sync_d;

  always_comb
  begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  genvar g;
  generate
    for (g = 0; g < DPC_NUM_INPUTS; g++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= meta_d[g];
          sync_q[g] <= sync_d[g];
        end
      end
    end
  endgenerate

  // until both stages have seen the pin, present the reset level
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  always_comb
  begin
    fill_d = fill_q;
    if (fill_q != 2'(DPC_SYNC_STAGES))
      fill_d = fill_q + 2'h1;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fill_q <= 2'h0;
    else
      fill_q <= fill_d;
  end
  always_comb
  begin
    sync_out = (fill_q == 2'(DPC_SYNC_STAGES)) ? sync_q : rst_val;
  end
endmodule : dpc_sync

// File: dpc_top.sv
module dpc_top
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reference_in,
  input wire logic feedback_in,
  input wire logic osc_disable,
  output logic xor_phase_out,
  output logic pull_up_en,
  output logic pull_dn_en,
  output logic edge_phase_out,
  output logic edge_phase_oe,
  output logic lock_indicator_out,
  output logic osc_enable,
  output logic follower_enable
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  logic [DPC_NUM_INPUTS-1:0] pins;
  logic [DPC_NUM_INPUTS-1:0] pins_s;
  logic [DPC_NUM_INPUTS-1:0] pins_rst;
  logic ref_s;
  logic fb_s;
  logic dis_s;

  always_comb
  begin
    pins[DPC_IDX_REF] = reference_in;
    pins[DPC_IDX_FB] = feedback_in;
    pins[DPC_IDX_DIS] = osc_disable;
    pins_rst[DPC_IDX_REF] = DPC_RST_LEVEL;
    pins_rst[DPC_IDX_FB] = DPC_RST_LEVEL;
    pins_rst[DPC_IDX_DIS] = DPC_RST_OSC_DIS;
  end

  dpc_sync u_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(pins),
    .rst_val(pins_rst),
    .sync_out(pins_s)
  );

  always_comb
  begin
    ref_s = pins_s[DPC_IDX_REF];
    fb_s = pins_s[DPC_IDX_FB];
    dis_s = pins_s[DPC_IDX_DIS];
  end

  // ----------------------------------------------------------------------
  // state decode helpers
  // ----------------------------------------------------------------------
  function automatic dpc_mode_t mode_of(input dpc_state_t s);
    logic [3:0] b;
    b = s;
    case (b[3:2])
      2'b01: mode_of = DPC_MODE_UP;
      2'b11: mode_of = DPC_MODE_DN;
      default: mode_of = DPC_MODE_OFF;
    endcase
  endfunction : mode_of

  function automatic dpc_state_t state_of(input dpc_mode_t m,
                                          input logic r,
                                          input logic f);
    logic [1:0] lv;
    lv = {r, f};
    state_of = DPC_ST1;
    case (m)
      DPC_MODE_UP:
        case (lv)
          2'b00: state_of = DPC_ST9;
          2'b01: state_of = DPC_ST11;
          2'b10: state_of = DPC_ST3;
          default: state_of = DPC_ST5;
        endcase
      DPC_MODE_DN:
        case (lv)
          2'b00: state_of = DPC_ST2;
          2'b01: state_of = DPC_ST4;
          2'b10: state_of = DPC_ST10;
          default: state_of = DPC_ST12;
        endcase
      default:
        case (lv)
          2'b00: state_of = DPC_ST1;
          2'b01: state_of = DPC_ST6;
          2'b10: state_of = DPC_ST7;
          default: state_of = DPC_ST8;
        endcase
    endcase
  endfunction : state_of

  // ----------------------------------------------------------------------
  // edge comparator state machine
  // ----------------------------------------------------------------------
  dpc_state_t state_q;
  dpc_state_t state_d;
  logic [3:0] state_bits;
  logic ref_lvl;
  logic fb_lvl;
  logic ref_rise;
  logic fb_rise;
  dpc_mode_t mode_cur;
  dpc_mode_t mode_nxt;

  always_comb
  begin
    state_bits = state_q;
    ref_lvl = state_bits[1];
    fb_lvl = state_bits[0];
    ref_rise = ref_s & ~ref_lvl;
    fb_rise = fb_s & ~fb_lvl;
    mode_cur = mode_of(state_q);
    mode_nxt = mode_cur;
    case (mode_cur)
      DPC_MODE_OFF:
      begin
        // both rising together is undefined; hold the mode
        if (ref_rise && !fb_rise)
          mode_nxt = DPC_MODE_UP;
        else if (fb_rise && !ref_rise)
          mode_nxt = DPC_MODE_DN;
      end
      DPC_MODE_UP:
      begin
        if (fb_rise)
          mode_nxt = DPC_MODE_OFF;
      end
      DPC_MODE_DN:
      begin
        if (ref_rise)
          mode_nxt = DPC_MODE_OFF;
      end
      default: mode_nxt = DPC_MODE_OFF;
    endcase
    state_d = state_of(mode_nxt, ref_s, fb_s);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= DPC_RST_STATE;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  logic xor_q;
  logic xor_d;
  logic up_q;
  logic up_d;
  logic dn_q;
  logic dn_d;
  logic lock_q;
  logic lock_d;
  logic osc_q;
  logic osc_d;
  logic oe_q;
  logic oe_d;

  always_comb
  begin
    xor_d = ref_s ^ fb_s;
    up_d = 1'b0;
    dn_d = 1'b0;
    lock_d = 1'b0;
    case (state_d)
      DPC_ST3, DPC_ST5, DPC_ST9, DPC_ST11: up_d = 1'b1;
      DPC_ST2, DPC_ST4, DPC_ST10, DPC_ST12: dn_d = 1'b1;
      DPC_ST1, DPC_ST6, DPC_ST7, DPC_ST8: lock_d = 1'b1;
      default: lock_d = 1'b0;
    endcase
    oe_d = up_d | dn_d;
    osc_d = ~dis_s;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xor_q <= DPC_RST_LEVEL;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      lock_q <= DPC_RST_LOCK;
      osc_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      xor_q <= xor_d;
      up_q <= up_d;
      dn_q <= dn_d;
      lock_q <= lock_d;
      osc_q <= osc_d;
      oe_q <= oe_d;
    end
  end

  // drive value equals pull-up; enable when either driver on
  always_comb
  begin
    xor_phase_out = xor_q;
    pull_up_en = up_q;
    pull_dn_en = dn_q;
    edge_phase_out = up_q;
    edge_phase_oe = oe_q;
    lock_indicator_out = lock_q;
    osc_enable = osc_q;
    follower_enable = osc_q;
  end
endmodule : dpc_top

// File: dpc_monitor.sv
// ----
// port checks
// ----
module dpc_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reference_in,
  input wire logic feedback_in,
  input wire logic osc_disable,
  input wire logic xor_phase_out,
  input wire logic pull_up_en,
  input wire logic pull_dn_en,
  input wire logic edge_phase_out,
  input wire logic edge_phase_oe,
  input wire logic lock_indicator_out,
  input wire logic osc_enable,
  input wire logic follower_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence ref_up3;
    $past(reference_in, 3) && !$past(reference_in, 4);
  endsequence
  sequence fb_up3;
    $past(feedback_in, 3) && !$past(feedback_in, 4);
  endsequence
  sequence float_ref;
    ($stable(reference_in) && $stable(feedback_in))[*2] ##1
    ($rose(reference_in) && $stable(feedback_in) && lock_indicator_out);
  endsequence
  xor_out_a: assert property (
    xor_phase_out == $past(reference_in ^ feedback_in, 3)) else $error("xor");
  tri_pin_a: assert property (
    edge_phase_oe == (pull_up_en ^ pull_dn_en) &&
    (!edge_phase_oe || edge_phase_out == pull_up_en)) else $error("tri");
  lock_flag_a: assert property (
    lock_indicator_out != edge_phase_oe) else $error("lock");
  osc_en_a: assert property (
    osc_enable == !$past(osc_disable, 3) && follower_enable == osc_enable)
    else $error("osc");
  up_start_a: assert property (
    $rose(pull_up_en) |-> ref_up3) else $error("up start");
  dn_start_a: assert property (
    $rose(pull_dn_en) |-> fb_up3) else $error("dn start");
  up_end_a: assert property (
    $fell(pull_up_en) |-> fb_up3) else $error("up end");
  float_up_a: assert property (
    float_ref |-> ##3 pull_up_en) else $error("float up");
endmodule : dpc_monitor
bind dpc_top dpc_monitor mon (.*);

// File: dpc_loop_model.sv
// ----
// loop filter, oscillator and divider
// ----
module dpc_loop_model (
  input wire logic clk,
  input wire logic run,
  input wire logic track,
  input wire logic up,
  input wire logic dn,
  input wire logic ref_in,
  input wire logic [7:0] half,
  output logic fb
);
  timeunit 1ns;
  timeprecision 1ns;
  int acc = 0;
  logic ref_q;
  initial fb = 1'b0;
  always @(posedge clk)
    ref_q <= ref_in;
  // drives nudge the phase while tracking
  always @(negedge clk)
  begin
    #1;
    if (run)
      acc += track ? 1 + int'(up === 1'b1) - int'(dn === 1'b1) : 1;
    if (acc >= half && ref_in === ref_q)
    begin
      acc = 0;
      fb = ~fb;
    end
  end
endmodule : dpc_loop_model

// File: dpc_top_test.sv
// ----
// bench
// ----
module dpc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, rs = 1'b0, dis = 1'b1, trk = 1'b0;
  logic fb, xo, up, dn, eo, oe, lk, oen, fen;
  logic [7:0] half = 8'h14;
  int err_total, compares, cycles, nu, nd, nl;
  dpc_top uut (.clk, .rst_b, .reference_in(rs), .feedback_in(fb),
    .osc_disable(dis), .xor_phase_out(xo), .pull_up_en(up), .pull_dn_en(dn),
    .edge_phase_out(eo), .edge_phase_oe(oe), .lock_indicator_out(lk),
    .osc_enable(oen), .follower_enable(fen));
  dpc_loop_model far (.clk, .run(oen), .track(trk), .up, .dn, .ref_in(rs),
    .half, .fb);
  initial forever #25 clk = ~clk;
  always @(posedge clk)
    if (++cycles == 4000)
      results(1'b1);
  task automatic chk(string nm, logic s, logic e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %b got %b", nm, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic results(logic hung);
    err_total += int'(hung);
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic t_up();
    for (int i = 0; i < 3; i++)
    begin
      rs = ~i[0];
      cyc(3);
      chk("xor", xo, ~i[0]);
      chk("up", up & ~dn & eo & oe & ~lk, 1'b1);
      chk("osc", oen | fen, 1'b0);
    end
  endtask : t_up
  task automatic t_dn();
    dis = 1'b0;
    cyc(3);
    chk("osc", oen & fen, 1'b1);
    for (int i = 0; i < 60 && up === 1'b1; i++)
      cyc(1);
    chk("float", ~oe & lk, 1'b1);
    for (int i = 0; i < 60 && dn !== 1'b1; i++)
      cyc(1);
    chk("dn", dn & oe & ~eo & ~lk, 1'b1);
    rs = 1'b0;
    cyc(4);
    rs = 1'b1;
    cyc(3);
    chk("dn end", ~dn & lk, 1'b1);
  endtask : t_dn
  // counts drive and lock cycles once the loop has settled
  task automatic t_run(int hr, logic t);
    trk = t;
    {nu, nd, nl} = 96'h0;
    for (int i = 0; i < 600; i++)
    begin
      if (i % hr == 0)
        rs = ~rs;
      cyc(1);
      nu += int'(i >= 200 && up === 1'b1);
      nd += int'(i >= 200 && dn === 1'b1);
      nl += int'(i >= 200 && lk === 1'b1);
    end
  endtask : t_run
  task automatic t_fast();
    t_run(5, 1'b0);
    chk("faster", nu > 200 && nd == 0, 1'b1);
  endtask : t_fast
  task automatic t_slow();
    t_run(60, 1'b0);
    chk("slower", nd > 200 && nu == 0, 1'b1);
  endtask : t_slow
  task automatic t_lock();
    t_run(20, 1'b1);
    chk("locked", nl > 300, 1'b1);
  endtask : t_lock
  initial
  begin
    cyc(20);
    rst_b = 1'b1;
    cyc(4);
    t_up();
    t_dn();
    t_fast();
    t_slow();
    t_lock();
    results(1'b0);
  end
endmodule : dpc_top_test
